/* File: inc/flash_cmd_pkg.sv */
// constants, states and carrier types for the flash command sequencer
//
// Notes on behaviour
// - whole-array erase (C7h/60h) needs the write latch bit set, else nothing.
// - erase opcode counts only if chip select rises right after bit eight.
// - accepted erase runs self-timed; busy high meanwhile; write latch cleared before end.
// - erase runs only when all block protect bits are zero.
// - B9h plus exact chip select rise enters power-down after a fixed delay.
// - in power-down every opcode but ABh is ignored; ABh releases.
// - power-down opcode during a busy cycle is rejected, cycle untouched.
// - ABh, three dummy bytes, then device code repeated MSB first on falling edges.
// - ABh ignored while busy; running cycle continues.
// - 90h plus address; address bit zero selects maker-first or device-first order.
// - 92h same read with address and data on two lines.
// - 94h same read on four lines with four dummy clocks after address.
// - 9Fh shifts out maker, memory type, capacity; chip select rise ends it.
// - 9Fh not decoded while erase or program runs.
// - A3h plus three dummy bytes enters high performance; ABh or B9h leaves it.
// - 75h accepted only with program/erase running, no suspend flag, busy high.
// - accepted suspend sets its flag at once and drops busy within the latency.
// - while suspended, status write, security, erase and program opcodes are refused.
// - 7Ah accepted with a flag set and busy low; flag clears, busy returns within 200ns.
package flash_cmd_pkg;
   // ============================================================
   // opcodes
   localparam logic [7:0] OP_ERASE_A = 8'hc7;
   localparam logic [7:0] OP_ERASE_B = 8'h60;
   localparam logic [7:0] OP_PWR_DOWN = 8'hb9;
   localparam logic [7:0] OP_RELEASE = 8'hab;
   localparam logic [7:0] OP_MAKER_DEV = 8'h90;
   localparam logic [7:0] OP_MAKER_DEV_X2 = 8'h92;
   localparam logic [7:0] OP_MAKER_DEV_X4 = 8'h94;
   localparam logic [7:0] OP_IDENT3 = 8'h9f;
   localparam logic [7:0] OP_HIGH_PERF = 8'ha3;
   localparam logic [7:0] OP_SUSPEND = 8'h75;
   localparam logic [7:0] OP_RESUME = 8'h7a;
   localparam logic [7:0] OP_WRSR_A = 8'h01;
   localparam logic [7:0] OP_WRSR_B = 8'h31;
   localparam logic [7:0] OP_WRSR_C = 8'h11;
   localparam logic [7:0] OP_SEC_ERASE = 8'h44;
   localparam logic [7:0] OP_SEC_PROG = 8'h42;
   localparam logic [7:0] OP_SECT_ERASE = 8'h20;
   localparam logic [7:0] OP_BLK32_ERASE = 8'h52;
   localparam logic [7:0] OP_BLK64_ERASE = 8'hd8;
   localparam logic [7:0] OP_PAGE_PROG = 8'h02;
   localparam logic [7:0] OP_PAGE_PROG_X4 = 8'h32;
   // ============================================================
   // frame geometry
   localparam logic [5:0] OPC_BITS = 6'h08;
   localparam logic [5:0] ADDR_BITS = 6'h18;
   localparam logic [5:0] QUAD_DUMMY_CLKS = 6'h04;
   localparam logic [2:0] LANE_1 = 3'h1;
   localparam logic [2:0] LANE_2 = 3'h2;
   localparam logic [2:0] LANE_4 = 3'h4;
   localparam int unsigned OUT_BITS = 48;
   // ============================================================
   // timing, figures in their own units
   localparam int unsigned CLK_MHZ = 100;
   localparam int unsigned ARRAY_ERASE_TIME_MS = 20;
   localparam int unsigned POWER_DOWN_ENTRY_DELAY_NS = 3000;
   localparam int unsigned RELEASE_DELAY_NS = 3000;
   localparam int unsigned RELEASE_WITH_CODE_DELAY_NS = 6000;
   localparam int unsigned SUSPEND_LATENCY_NS = 20000;
   localparam int unsigned RESUME_BUSY_NS = 200;
   localparam int unsigned ERASE_CYC = ARRAY_ERASE_TIME_MS * CLK_MHZ * 1000;
   localparam int unsigned DP_CYC = POWER_DOWN_ENTRY_DELAY_NS * CLK_MHZ / 1000;
   localparam int unsigned RES1_CYC = RELEASE_DELAY_NS * CLK_MHZ / 1000;
   localparam int unsigned RES2_CYC = RELEASE_WITH_CODE_DELAY_NS * CLK_MHZ / 1000;
   localparam int unsigned SUS_CYC = SUSPEND_LATENCY_NS * CLK_MHZ / 1000;
   localparam int unsigned RESUME_CYC = RESUME_BUSY_NS * CLK_MHZ / 1000;
   // ============================================================
   // frame states
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_OPC = 6'h02,
      ST_ADDR = 6'h04,
      ST_DUMMY = 6'h08,
      ST_OUT = 6'h10,
      ST_TAIL = 6'h20
   } frame_e;
   localparam frame_e ST_IGNORE = ST_IDLE;
   // ============================================================
   // carriers
   typedef struct packed {
      logic cs_n;
      logic sclk;
      logic [3:0] io;
   } spi_pins_s;
   typedef struct packed {
      logic [3:0] io_out;
      logic [3:0] io_oe;
   } spi_drive_s;
   typedef struct packed {
      logic busy_bit;
      logic [1:0] suspend_flags;
      logic deep_power_down;
      logic high_perf_mode;
      logic releasing;
   } flash_status_s;
endpackage : flash_cmd_pkg

/* File: hdl/cycle_timer.sv */
// one-shot down counter for self-timed delays
`timescale 1ns/1ps
module cycle_timer #(
   parameter int unsigned CYC = 1
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // control
   input wire logic start,
   output logic run,
   output logic done
);
   logic [31:0] cnt_ff;
   logic run_ff;
   wire last = run_ff && (cnt_ff <= 32'h1);
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         cnt_ff <= 32'h0;
         run_ff <= 1'b0;
      end else if (start) begin
         cnt_ff <= (CYC < 1) ? 32'h1 : 32'(CYC);
         run_ff <= 1'b1;
      end else if (run_ff) begin
         cnt_ff <= cnt_ff - 32'h1;
         run_ff <= !last;
      end
   end
   assign run = run_ff;
   assign done = last && !start;
endmodule : cycle_timer

/* File: hdl/flash_cmd_seq.sv */
// serial flash command sequencer: erase, power-down, identification, suspend
`timescale 1ns/1ps
module flash_cmd_seq #(
   parameter int unsigned ERASE_CYC = flash_cmd_pkg::ERASE_CYC,
   parameter int unsigned DP_CYC = flash_cmd_pkg::DP_CYC,
   parameter int unsigned RES1_CYC = flash_cmd_pkg::RES1_CYC,
   parameter int unsigned RES2_CYC = flash_cmd_pkg::RES2_CYC,
   parameter int unsigned SUS_CYC = flash_cmd_pkg::SUS_CYC,
   parameter logic [7:0] MAKER_CODE = 8'h5a, // arbitrary
   parameter logic [7:0] DEVICE_CODE = 8'h3c, // arbitrary
   parameter logic [7:0] MEM_TYPE = 8'h41, // arbitrary
   parameter logic [7:0] CAPACITY = 8'h17 // arbitrary
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // serial pins
   input wire flash_cmd_pkg::spi_pins_s pins,
   output flash_cmd_pkg::spi_drive_s drive,
   // neighbouring logic
   input wire logic write_latch_bit,
   input wire logic [2:0] block_protect_bits,
   input wire logic pgm_erase_running,
   input wire logic pgm_is_program,
   input wire logic status_write_running,
   // status and events
   output flash_cmd_pkg::flash_status_s status,
   output logic wel_clear,
   output logic pgm_erase_hold,
   output logic cmd_refused
);
   // ============================================================
   // pin synchroniser and edges
   flash_cmd_pkg::spi_pins_s s1_ff, s2_ff, s3_ff;
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         s1_ff <= '{cs_n: 1'b1, sclk: 1'b0, io: 4'h0};
         s2_ff <= '{cs_n: 1'b1, sclk: 1'b0, io: 4'h0};
         s3_ff <= '{cs_n: 1'b1, sclk: 1'b0, io: 4'h0};
      end else begin
         s1_ff <= pins;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end
   wire sclk_rise = s2_ff.sclk && !s3_ff.sclk && !s2_ff.cs_n;
   wire sclk_fall = !s2_ff.sclk && s3_ff.sclk && !s2_ff.cs_n;
   wire cs_fall = !s2_ff.cs_n && s3_ff.cs_n;
   wire cs_rise = s2_ff.cs_n && !s3_ff.cs_n;

   // ============================================================
   // frame state
   flash_cmd_pkg::frame_e st_ff;
   logic [7:0] op_ff;
   logic [5:0] cnt_ff;
   logic [2:0] lw_ff;
   logic [47:0] out_ff;
   logic oe_ff;
   logic aborted_ff;
   logic deep_pd_ff, hpm_ff, sus_done_ff, pd_code_ff;
   logic [1:0] sus_ff;

   wire ce_run, dp_run, dp_done, rel1_run, rel2_run, sus_done;
   wire suspended = |sus_ff;
   wire busy = ce_run || status_write_running || (pgm_erase_running && !sus_done_ff);
   wire releasing = rel1_run || rel2_run;

   // incoming bits of this edge
   wire [3:0] chunk = (lw_ff == flash_cmd_pkg::LANE_4) ? s2_ff.io :
                      (lw_ff == flash_cmd_pkg::LANE_2) ? {2'h0, s2_ff.io[1:0]} : {3'h0, s2_ff.io[0]};
   wire [5:0] cnt_nxt = cnt_ff + {3'h0, lw_ff};
   wire [7:0] op_nxt = {op_ff[6:0], s2_ff.io[0]};
   wire op_dec = (st_ff == flash_cmd_pkg::ST_OPC) && sclk_rise && (cnt_nxt == flash_cmd_pkg::OPC_BITS);
   wire addr_last = (st_ff == flash_cmd_pkg::ST_ADDR) && sclk_rise && (cnt_nxt == flash_cmd_pkg::ADDR_BITS);
   wire dummy_last = (st_ff == flash_cmd_pkg::ST_DUMMY) && sclk_rise
                     && (cnt_nxt == flash_cmd_pkg::QUAD_DUMMY_CLKS);

   // opcode classes
   wire is_erase = (op_nxt == flash_cmd_pkg::OP_ERASE_A) || (op_nxt == flash_cmd_pkg::OP_ERASE_B);
   wire is_id = (op_nxt == flash_cmd_pkg::OP_MAKER_DEV) || (op_nxt == flash_cmd_pkg::OP_MAKER_DEV_X2)
                || (op_nxt == flash_cmd_pkg::OP_MAKER_DEV_X4);
   wire is_tail = is_erase || (op_nxt == flash_cmd_pkg::OP_PWR_DOWN)
                  || (op_nxt == flash_cmd_pkg::OP_SUSPEND) || (op_nxt == flash_cmd_pkg::OP_RESUME);
   wire is_refusable = is_erase || (op_nxt == flash_cmd_pkg::OP_WRSR_A) || (op_nxt == flash_cmd_pkg::OP_WRSR_B)
                       || (op_nxt == flash_cmd_pkg::OP_WRSR_C) || (op_nxt == flash_cmd_pkg::OP_SEC_ERASE)
                       || (op_nxt == flash_cmd_pkg::OP_SEC_PROG) || (op_nxt == flash_cmd_pkg::OP_SECT_ERASE)
                       || (op_nxt == flash_cmd_pkg::OP_BLK32_ERASE) || (op_nxt == flash_cmd_pkg::OP_BLK64_ERASE)
                       || (op_nxt == flash_cmd_pkg::OP_PAGE_PROG) || (op_nxt == flash_cmd_pkg::OP_PAGE_PROG_X4);
   wire refuse_now = op_dec && suspended && is_refusable;
   wire gate_pd = deep_pd_ff && (op_nxt != flash_cmd_pkg::OP_RELEASE);
   wire gate_busy = busy && ((op_nxt == flash_cmd_pkg::OP_RELEASE)
                    || (op_nxt == flash_cmd_pkg::OP_IDENT3));
   wire drop_op = gate_pd || gate_busy || releasing || refuse_now;

   // identification patterns, repeating through a 48-bit ring
   wire [47:0] pat_rel = {6{DEVICE_CODE}};
   wire [47:0] pat_md = {3{MAKER_CODE, DEVICE_CODE}};
   wire [47:0] pat_dm = {3{DEVICE_CODE, MAKER_CODE}};
   wire [47:0] pat_id3 = {2{MAKER_CODE, MEM_TYPE, CAPACITY}};
   wire [47:0] pat_addr = (op_ff == flash_cmd_pkg::OP_RELEASE) ? pat_rel : (chunk[0] ? pat_dm : pat_md);
   wire [47:0] rot1 = {out_ff[46:0], out_ff[47]};
   wire [47:0] rot2 = {out_ff[45:0], out_ff[47:46]};
   wire [47:0] rot4 = {out_ff[43:0], out_ff[47:44]};
   wire [47:0] rot = (lw_ff == flash_cmd_pkg::LANE_4) ? rot4 : (lw_ff == flash_cmd_pkg::LANE_2) ? rot2 : rot1;

   // ============================================================
   // actions at the closing chip select edge
   wire tail_ok = cs_rise && (st_ff == flash_cmd_pkg::ST_TAIL) && !aborted_ff;
   wire ce_start = tail_ok && ((op_ff == flash_cmd_pkg::OP_ERASE_A) || (op_ff == flash_cmd_pkg::OP_ERASE_B))
                   && write_latch_bit && (block_protect_bits == 3'h0)
                   && !busy && !suspended;
   wire dp_start = tail_ok && (op_ff == flash_cmd_pkg::OP_PWR_DOWN) && !busy;
   wire sus_accept = tail_ok && (op_ff == flash_cmd_pkg::OP_SUSPEND) && pgm_erase_running
                     && busy && !suspended;
   wire res_accept = tail_ok && (op_ff == flash_cmd_pkg::OP_RESUME) && suspended && !busy;
   wire hpm_enter = tail_ok && (op_ff == flash_cmd_pkg::OP_HIGH_PERF);
   wire rel_bare = cs_rise && (st_ff == flash_cmd_pkg::ST_ADDR) && (op_ff == flash_cmd_pkg::OP_RELEASE)
                   && (cnt_ff == 6'h00) && !busy;
   wire rel_code = cs_rise && (st_ff == flash_cmd_pkg::ST_OUT) && (op_ff == flash_cmd_pkg::OP_RELEASE);
   wire rel1_start = rel_bare && deep_pd_ff;
   wire rel2_start = rel_code && pd_code_ff;

   // ============================================================
   // self-timed delays
   cycle_timer #(.CYC(ERASE_CYC)) u_erase (.clk_sys(clk_sys), .rst_n(rst_n), .start(ce_start),
      .run(ce_run), .done());
   cycle_timer #(.CYC(DP_CYC)) u_pd (.clk_sys(clk_sys), .rst_n(rst_n), .start(dp_start),
      .run(dp_run), .done(dp_done));
   cycle_timer #(.CYC(RES1_CYC)) u_rel1 (.clk_sys(clk_sys), .rst_n(rst_n), .start(rel1_start),
      .run(rel1_run), .done());
   cycle_timer #(.CYC(RES2_CYC)) u_rel2 (.clk_sys(clk_sys), .rst_n(rst_n), .start(rel2_start),
      .run(rel2_run), .done());
   cycle_timer #(.CYC(SUS_CYC)) u_sus (.clk_sys(clk_sys), .rst_n(rst_n), .start(sus_accept),
      .run(), .done(sus_done));

   // ============================================================
   // frame sequencer
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         st_ff <= flash_cmd_pkg::ST_IDLE;
         op_ff <= 8'h00;
         cnt_ff <= 6'h00;
         lw_ff <= flash_cmd_pkg::LANE_1;
         out_ff <= 48'h0;
         oe_ff <= 1'b0;
         aborted_ff <= 1'b0;
         pd_code_ff <= 1'b0;
      end else if (cs_fall) begin
         st_ff <= flash_cmd_pkg::ST_OPC;
         cnt_ff <= 6'h00;
         lw_ff <= flash_cmd_pkg::LANE_1;
         op_ff <= 8'h00;
         oe_ff <= 1'b0;
         aborted_ff <= 1'b0;
         pd_code_ff <= deep_pd_ff;
      end else if (s2_ff.cs_n) begin
         st_ff <= flash_cmd_pkg::ST_IDLE;
         oe_ff <= 1'b0;
      end else begin
         case (st_ff)
            flash_cmd_pkg::ST_OPC: begin
               if (sclk_rise) begin
                  op_ff <= op_nxt;
                  cnt_ff <= op_dec ? 6'h00 : cnt_nxt;
               end
               if (op_dec) begin
                  if (drop_op) begin
                     st_ff <= flash_cmd_pkg::ST_IGNORE;
                  end else if (is_tail) begin
                     st_ff <= flash_cmd_pkg::ST_TAIL;
                  end else if (op_nxt == flash_cmd_pkg::OP_IDENT3) begin
                     st_ff <= flash_cmd_pkg::ST_OUT;
                     out_ff <= pat_id3;
                  end else if (is_id || (op_nxt == flash_cmd_pkg::OP_RELEASE)
                               || (op_nxt == flash_cmd_pkg::OP_HIGH_PERF)) begin
                     st_ff <= flash_cmd_pkg::ST_ADDR;
                     lw_ff <= (op_nxt == flash_cmd_pkg::OP_MAKER_DEV_X4) ? flash_cmd_pkg::LANE_4 :
                              (op_nxt == flash_cmd_pkg::OP_MAKER_DEV_X2) ? flash_cmd_pkg::LANE_2 :
                              flash_cmd_pkg::LANE_1;
                  end else begin
                     st_ff <= flash_cmd_pkg::ST_IGNORE;
                  end
               end
            end
            flash_cmd_pkg::ST_ADDR: begin
               if (sclk_rise) begin
                  cnt_ff <= addr_last ? 6'h00 : cnt_nxt;
               end
               if (addr_last) begin
                  out_ff <= pat_addr;
                  if (op_ff == flash_cmd_pkg::OP_HIGH_PERF) begin
                     st_ff <= flash_cmd_pkg::ST_TAIL;
                  end else if (op_ff == flash_cmd_pkg::OP_MAKER_DEV_X4) begin
                     st_ff <= flash_cmd_pkg::ST_DUMMY;
                     lw_ff <= flash_cmd_pkg::LANE_1;
                  end else begin
                     st_ff <= flash_cmd_pkg::ST_OUT;
                  end
               end
            end
            flash_cmd_pkg::ST_DUMMY: begin
               if (sclk_rise) begin
                  cnt_ff <= cnt_nxt;
               end
               if (dummy_last) begin
                  st_ff <= flash_cmd_pkg::ST_OUT;
                  lw_ff <= flash_cmd_pkg::LANE_4;
               end
            end
            flash_cmd_pkg::ST_OUT: begin
               if (sclk_fall) begin
                  oe_ff <= 1'b1;
                  if (oe_ff) begin
                     out_ff <= rot;
                  end
               end
            end
            flash_cmd_pkg::ST_TAIL: begin
               if (sclk_rise) begin
                  aborted_ff <= 1'b1;
               end
            end
            default: begin
               st_ff <= flash_cmd_pkg::ST_IGNORE;
            end
         endcase
      end
   end

   // ============================================================
   // mode and suspend flags
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         deep_pd_ff <= 1'b0;
         hpm_ff <= 1'b0;
         sus_ff <= 2'h0;
         sus_done_ff <= 1'b0;
      end else begin
         if (dp_done) begin
            deep_pd_ff <= 1'b1;
         end else if (rel_bare || rel_code) begin
            deep_pd_ff <= 1'b0;
         end
         if (hpm_enter) begin
            hpm_ff <= 1'b1;
         end else if (dp_start || rel_bare || rel_code) begin
            hpm_ff <= 1'b0;
         end
         if (sus_accept) begin
            sus_ff <= pgm_is_program ? 2'h2 : 2'h1;
         end else if (res_accept) begin
            sus_ff <= 2'h0;
         end
         if (sus_done) begin
            sus_done_ff <= 1'b1;
         end else if (res_accept) begin
            sus_done_ff <= 1'b0;
         end
      end
   end

   // ============================================================
   // outputs
   assign drive.io_out = (lw_ff == flash_cmd_pkg::LANE_4) ? out_ff[47:44] :
                         (lw_ff == flash_cmd_pkg::LANE_2) ? {2'h0, out_ff[47:46]} : {2'h0, out_ff[47], 1'b0};
   assign drive.io_oe = !oe_ff ? 4'h0 : (lw_ff == flash_cmd_pkg::LANE_4) ? 4'hf :
                        (lw_ff == flash_cmd_pkg::LANE_2) ? 4'h3 : 4'h2;
   assign status.busy_bit = busy;
   assign status.suspend_flags = sus_ff;
   assign status.deep_power_down = deep_pd_ff;
   assign status.high_perf_mode = hpm_ff;
   assign status.releasing = releasing || dp_run;
   assign wel_clear = ce_start;
   assign pgm_erase_hold = suspended;
   assign cmd_refused = refuse_now;

   // ============================================================
   // checks
   property p_ce_guard;
      @(posedge clk_sys) disable iff (!rst_n)
      ce_start |-> write_latch_bit && (block_protect_bits == 3'h0) && !aborted_ff;
   endproperty
   a_ce_guard: assert property (p_ce_guard) else $error("erase started without latch or with protection");
   property p_ce_busy;
      @(posedge clk_sys) disable iff (!rst_n)
      ce_start |-> wel_clear ##1 status.busy_bit [*4];
   endproperty
   a_ce_busy: assert property (p_ce_busy) else $error("erase did not show busy");
   property p_tail_abort;
      @(posedge clk_sys) disable iff (!rst_n)
      cs_rise && (st_ff == flash_cmd_pkg::ST_TAIL) && aborted_ff |-> !ce_start && !dp_start && !hpm_enter;
   endproperty
   a_tail_abort: assert property (p_tail_abort) else $error("command ran after extra clock");
   property p_dp_reject;
      @(posedge clk_sys) disable iff (!rst_n)
      busy && tail_ok && (op_ff == flash_cmd_pkg::OP_PWR_DOWN) |=> !dp_run && $stable(status.busy_bit);
   endproperty
   a_dp_reject: assert property (p_dp_reject) else $error("power-down accepted while busy");
   property p_pd_ignore;
      @(posedge clk_sys) disable iff (!rst_n)
      op_dec && deep_pd_ff && (op_nxt != flash_cmd_pkg::OP_RELEASE) |=> (st_ff == flash_cmd_pkg::ST_IGNORE);
   endproperty
   a_pd_ignore: assert property (p_pd_ignore) else $error("command decoded in power-down");
   property p_rel_busy;
      @(posedge clk_sys) disable iff (!rst_n)
      op_dec && busy && (op_nxt == flash_cmd_pkg::OP_RELEASE) |=> (st_ff == flash_cmd_pkg::ST_IGNORE);
   endproperty
   a_rel_busy: assert property (p_rel_busy) else $error("release decoded while busy");
   property p_id3_busy;
      @(posedge clk_sys) disable iff (!rst_n)
      op_dec && busy && (op_nxt == flash_cmd_pkg::OP_IDENT3) |=> !oe_ff [*3];
   endproperty
   a_id3_busy: assert property (p_id3_busy) else $error("ident read decoded while busy");
   property p_sus_flag;
      @(posedge clk_sys) disable iff (!rst_n)
      sus_accept |-> status.busy_bit ##1 (status.suspend_flags != 2'h0) && pgm_erase_hold;
   endproperty
   a_sus_flag: assert property (p_sus_flag) else $error("suspend flag not set at once");
   property p_resume;
      @(posedge clk_sys) disable iff (!rst_n)
      res_accept |=> (status.suspend_flags == 2'h0) ##[0:20] (status.busy_bit || !pgm_erase_running);
   endproperty
   a_resume: assert property (p_resume) else $error("resume did not restore busy in time");
   property p_refuse;
      @(posedge clk_sys) disable iff (!rst_n)
      refuse_now |=> (st_ff == flash_cmd_pkg::ST_IGNORE) && !ce_run;
   endproperty
   a_refuse: assert property (p_refuse) else $error("refused opcode acted while suspended");
endmodule : flash_cmd_seq

/* File: tb/spi_host_model.sv */
// spi host model driving chip select, serial clock and one, two or four data lanes
`timescale 1ns/1ps
module spi_host_model (
   // clock
   input wire logic clk_sys,
   // serial pins
   output flash_cmd_pkg::spi_pins_s pins,
   input wire flash_cmd_pkg::spi_drive_s drive
);
   // ====================================
   // framed transfer, 80 ns serial clock, still between frames
   initial pins = 6'h20;
   task automatic frame(input logic [31:0] tx, input int ntx, input int nrx, input int w, output logic [23:0] rx);
      logic [31:0] sh;
      logic [3:0] q;
      int n;
      sh = tx;
      rx = 24'h0;
      @(posedge clk_sys) pins.cs_n <= 1'b0;
      repeat (4) @(posedge clk_sys);
      for (int i = 0; i < ntx + nrx; i++) begin
         // opcode on one line, then w lines per clock
         n = (i < 8) ? 1 : w;
         pins.sclk <= 1'b0;
         // a released line toggles instead of keeping its last value
         if (i >= ntx) pins.io <= ~pins.io;
         else if (n == 4) pins.io <= sh[31:28];
         else if (n == 2) pins.io <= {2'h0, sh[31:30]};
         else pins.io <= {3'h0, sh[31]};
         sh = sh << n;
         repeat (4) @(posedge clk_sys);
         pins.sclk <= 1'b1;
         // an undriven output shows the inverse of the last bit taken
         q = drive.io_oe[1] ? drive.io_out : {4{~rx[0]}};
         if (i >= ntx) rx = (w == 4) ? {rx[19:0], q} : (w == 2) ? {rx[21:0], q[1:0]} : {rx[22:0], q[1]};
         repeat (4) @(posedge clk_sys);
      end
      pins.sclk <= 1'b0;
      @(posedge clk_sys) pins.cs_n <= 1'b1;
      repeat (12) @(posedge clk_sys);
   endtask : frame
endmodule : spi_host_model

/* File: tb/flash_cmd_seq_tb.sv */
// self-checking bench for the flash command sequencer
`timescale 1ns/1ps
module flash_cmd_seq_tb;
   // ====================================
   // clock, reset, design and host
   localparam logic [7:0] MK = 8'h5a, DV = 8'h3c, MT = 8'h41, CP = 8'h17;
   localparam int DPC = 5, R1C = 5, R2C = 8;
   logic clk_sys = 1'b0, rst_n = 1'b0, wlb = 1'b0, program_erase_resume = 1'b0, swr = 1'b0, pip = 1'b0;
   logic [2:0] bp = 3'h0;
   logic [23:0] rx, a;
   logic wel_clear, cmd_refused, hold;
   logic [7:0] ops [12] = '{8'h01, 8'h31, 8'h11, 8'h44, 8'h42, 8'h20, 8'h52, 8'hd8, 8'hc7, 8'h60, 8'h02, 8'h32};
   flash_cmd_pkg::spi_pins_s pins;
   flash_cmd_pkg::spi_drive_s drive;
   flash_cmd_pkg::flash_status_s st;
   int bad_count = 0, samples_checked = 0, wel_n = 0, ref_n = 0, rel_n = 0, w = 1, seed = 91599;
   always #5 clk_sys = ~clk_sys;
   // counted mid-cycle: these outputs are launched on the rising edge
   always @(negedge clk_sys) begin
      if (wel_clear === 1'b1) wel_n <= wel_n + 1;
      if (cmd_refused === 1'b1) ref_n <= ref_n + 1;
      if (st.releasing === 1'b1) rel_n <= rel_n + 1;
   end
   flash_cmd_seq #(.ERASE_CYC(50), .DP_CYC(DPC), .RES1_CYC(R1C), .RES2_CYC(R2C), .SUS_CYC(10), .MAKER_CODE(MK),
      .DEVICE_CODE(DV), .MEM_TYPE(MT), .CAPACITY(CP)) dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .pins(pins),
      .drive(drive), .write_latch_bit(wlb), .block_protect_bits(bp), .pgm_erase_running(program_erase_resume),
      .pgm_is_program(pip), .status_write_running(swr), .status(st), .wel_clear(wel_clear),
      .pgm_erase_hold(hold), .cmd_refused(cmd_refused));
   spi_host_model host_u (.clk_sys(clk_sys), .pins(pins), .drive(drive));
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic finish_test;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : finish_test
   task automatic op(input logic [31:0] tx, input int ntx, input int nrx, input int lanes = 1);
      host_u.frame(tx, ntx, nrx, lanes, rx);
   endtask : op
   initial begin
      repeat (100000) @(posedge clk_sys);
      bad_count++;
      finish_test();
   end
   initial begin
      repeat (12) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (6) @(posedge clk_sys);
      op(32'h9f000000, 8, 24);
      check(rx, {MK, MT, CP});
      op(32'ha3000000, 32, 0);
      for (int k = 0; k < 6; k++) begin
         a = $random(seed);
         w = 1 << (k % 3);
         op({8'h90 + 8'(2 * (k % 3)), 23'h0, a[0]}, 8 + 24 / w + ((w == 4) ? 4 : 0), 16 / w, w);
         check(rx, a[0] ? {8'h00, DV, MK} : {8'h00, MK, DV});
      end
      op(32'hab000000, 32, 16);
      check(rx, {8'h00, DV, DV});
      bp <= 3'h4;
      wlb <= 1'b1;
      op(32'hc7000000, 8, 0);
      check(24'(st.busy_bit), 24'h0);
      bp <= 3'h0;
      wlb <= 1'b0;
      op(32'hc7000000, 8, 0);
      check(24'(st.busy_bit), 24'h0);
      wlb <= 1'b1;
      op(32'hc7000000, 9, 0);
      check(24'(st.busy_bit), 24'h0);
      op(32'h60000000, 8, 0);
      check(24'({st.busy_bit, 8'(wel_n)}), 24'h101);
      for (int i = 0; i < 300 && st.busy_bit !== 1'b0; i++) @(posedge clk_sys);
      check(24'(st.busy_bit), 24'h0);
      op(32'ha3000000, 32, 0);
      check(24'(st.high_perf_mode), 24'h1);
      swr <= 1'b1;
      op(32'hb9000000, 8, 0);
      check(24'(st.deep_power_down), 24'h0);
      op(32'h9f000000, 8, 24);
      check(rx, 24'haaaaaa);
      swr <= 1'b0;
      op(32'hb9000000, 8, 0);
      check(24'({st.deep_power_down, st.high_perf_mode, 8'(rel_n)}), {14'h0, 2'h2, 8'(DPC)});
      swr <= 1'b1;
      op(32'hab000000, 8, 0);
      check(24'(st.deep_power_down), 24'h1);
      swr <= 1'b0;
      op(32'ha3000000, 32, 0);
      check(24'(st.high_perf_mode), 24'h0);
      op(32'hab000000, 8, 0);
      check(24'({st.deep_power_down, 8'(rel_n)}), 24'(DPC + R1C));
      op(32'hb9000000, 8, 0);
      op(32'hab000000, 32, 16);
      check(rx, {8'h00, DV, DV});
      check(24'({st.deep_power_down, 8'(rel_n)}), 24'(2 * DPC + R1C + R2C));
      op(32'h75000000, 8, 0);
      check(24'(st.suspend_flags), 24'h0);
      a = $random(seed);
      pip <= a[1];
      program_erase_resume <= 1'b1;
      op(32'h75000000, 8, 0);
      repeat (4) @(posedge clk_sys);
      check(24'({st.suspend_flags, st.busy_bit, hold}), {20'h0, pip ? 2'h2 : 2'h1, 2'h1});
      foreach (ops[j]) op({ops[j], 24'h0}, 8, 0);
      check(24'(ref_n), 24'h00000c);
      op(32'h7a000000, 8, 0);
      check(24'({st.suspend_flags, st.busy_bit, hold}), 24'h2);
      finish_test();
   end
endmodule : flash_cmd_seq_tb
